// >>> hdl/eprom_seq.sv
// Purpose: Program/read sequencer for a 1024 x 8 socketed target memory part
// Assumes: All pin inputs synchronous to clk; Avalon-MM register slave
// Notes: Long counts are parameters so a bench can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "eprom_seq_defines.svh"
module eprom_seq
#(
  parameter int unsigned BURN_CYCLES = `BURN_CYC,
  parameter int unsigned INS_WINDOW_CYCLES = `INS_WINDOW_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [11:0] target_addr,
  input wire logic [7:0] write_byte,
  output logic [7:0] returned_byte,
  output logic returned_byte_oe,
  output logic range_fault_n,
  output logic insertion_fault,
  input wire logic [7:0] part_data_pins_in,
  output logic [7:0] part_data_pins_out,
  output logic part_data_pins_oe,
  output logic [1:0] upper_addr_port,
  output logic mode_direction_control,
  output logic part_reset_pulse_n,
  output logic ext_address_pin,
  output logic burn_pulse_pin,
  output logic supply_boost,
  input wire logic hv_present,
  input wire logic fetch_strobe
);
  import eprom_seq_pkg::*;

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam timer_t VERIFY_T = timer_t'(`VERIFY_CYC);
  localparam timer_t RESET_T = timer_t'(`RESET_CYC);
  localparam timer_t SETUP_T = timer_t'(`SETUP_CYC);
  localparam timer_t BURN_T = timer_t'(BURN_CYCLES);
  localparam timer_t INS_T = timer_t'(INS_WINDOW_CYCLES);
  localparam int CB = `INS_COUNT_BITS;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    seq_state_e st;
    timer_t tmr;
    logic op_burn_pulse_pin;
    logic retried;
    logic ack;
    logic [31:0] rdata;
    logic busy;
    logic done;
    logic ok;
    logic rng_err;
    logic ins_err;
    logic hv_err;
    logic vfy_err;
    logic [7:0] rb_inv;
    logic ret_gate;
    logic [CB-1:0] fcnt;
    logic strobe_prev;
    logic route_n;
    logic [7:0] pd_out;
    logic pd_oe;
    logic [1:0] upper;
    logic mode_dir;
    logic part_rst_n;
    logic ext_addr;
    logic burn;
    logic boost;
    logic range_n;
  } seq_s;

  seq_s q;
  seq_s d;

  logic [1:0] reg_sel;
  logic wr_ctrl;
  logic strobe_rise;
  logic addr_bad;
  logic tmr_zero;
  logic [7:0] readback_true;

  assign reg_sel = avs_address[3:2];
  assign wr_ctrl = avs_write && q.ack && reg_sel == `REG_CTRL &&
    avs_byteenable[0];
  assign strobe_rise = fetch_strobe && !q.strobe_prev;
  assign addr_bad = target_addr[11] | target_addr[10];
  assign tmr_zero = q.tmr == timer_t'(0);
  assign readback_true = ~q.rb_inv;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.strobe_prev = fetch_strobe;
    d.range_n = !addr_bad;
    if (!tmr_zero)
    begin
      d.tmr = q.tmr - timer_t'(1);
    end

    // Bus slave: one wait cycle, answer on the second edge
    d.ack = (avs_read || avs_write) && !q.ack;
    if ((avs_read || avs_write) && !q.ack)
    begin
      d.rdata = 32'h0000_0000;
      unique case (reg_sel)
        `REG_CTRL:
        begin
          d.rdata[`CTRL_RET_GATE] = q.ret_gate;
        end
        `REG_STATUS:
        begin
          d.rdata = {24'h00_0000, !q.range_n, q.vfy_err, q.hv_err,
            q.ins_err, q.rng_err, q.ok, q.done, q.busy};
        end
        `REG_READBACK:
        begin
          d.rdata = {24'h00_0000, readback_true};
        end
        `REG_ADDR:
        begin
          d.rdata = {20'h0_0000, target_addr};
        end
      endcase
    end

    // Control register: gate level and operation requests
    if (wr_ctrl)
    begin
      d.ret_gate = avs_writedata[`CTRL_RET_GATE];
    end

    unique case (q.st)
      ST_IDLE:
      begin
        if (wr_ctrl && (avs_writedata[`CTRL_GO_READ] ||
          avs_writedata[`CTRL_GO_BURN_PULSE_PIN]))
        begin
          d.op_burn_pulse_pin = avs_writedata[`CTRL_GO_BURN_PULSE_PIN];
          d.retried = 1'b0;
          d.busy = 1'b1;
          d.done = 1'b0;
          d.ok = 1'b0;
          d.rng_err = 1'b0;
          d.ins_err = 1'b0;
          d.hv_err = 1'b0;
          d.vfy_err = 1'b0;
          if (addr_bad)
          begin
            d.rng_err = 1'b1;
            d.st = ST_FINISH;
          end
          else if (avs_writedata[`CTRL_GO_BURN_PULSE_PIN] && !hv_present)
          begin
            d.hv_err = 1'b1;
            d.st = ST_FINISH;
          end
          else
          begin
            // Reset target and zero the fetch counter together
            d.part_rst_n = 1'b0;
            d.fcnt = '0;
            d.tmr = RESET_T;
            d.st = ST_PART_RESET;
          end
        end
      end

      ST_PART_RESET:
      begin
        if (tmr_zero)
        begin
          d.part_rst_n = 1'b1;
          d.tmr = INS_T;
          d.st = ST_INS_WAIT;
        end
      end

      ST_INS_WAIT:
      begin
        if (strobe_rise && !q.fcnt[CB-1])
        begin
          d.fcnt = q.fcnt + CB'(1);
        end
        if (tmr_zero)
        begin
          if (!q.fcnt[CB-1])
          begin
            d.ins_err = 1'b1;
            d.st = ST_FINISH;
          end
          else
          begin
            // Address phase: ext-address up, address on the pins
            d.ext_addr = 1'b1;
            d.route_n = 1'b0;
            d.pd_out = target_addr[7:0];
            d.upper = target_addr[9:8];
            d.mode_dir = 1'b0;
            d.pd_oe = 1'b1;
            d.tmr = SETUP_T;
            d.st = ST_ADDR_SET;
          end
        end
      end

      ST_ADDR_SET:
      begin
        if (tmr_zero)
        begin
          d.part_rst_n = 1'b0; // latch pulse
          d.tmr = RESET_T;
          d.st = ST_ADDR_LATCH;
        end
      end

      ST_ADDR_LATCH:
      begin
        if (tmr_zero)
        begin
          d.part_rst_n = 1'b1;
          d.tmr = SETUP_T;
          d.st = ST_ADDR_HOLD;
        end
      end

      ST_ADDR_HOLD:
      begin
        if (tmr_zero)
        begin
          if (q.op_burn_pulse_pin)
          begin
            d.route_n = 1'b1;
            d.pd_out = write_byte;
            d.boost = 1'b1;
            d.tmr = SETUP_T;
            d.st = ST_DATA_SET;
          end
          else
          begin
            d.pd_oe = 1'b0;
            d.mode_dir = 1'b1;
            d.tmr = VERIFY_T;
            d.st = ST_VERIFY;
          end
        end
      end

      ST_DATA_SET:
      begin
        if (tmr_zero)
        begin
          // All eight bits burned in one pulse
          d.burn = 1'b1;
          d.tmr = BURN_T;
          d.st = ST_BURN;
        end
      end

      ST_BURN:
      begin
        if (tmr_zero)
        begin
          d.burn = 1'b0;
          d.boost = 1'b0;
          d.tmr = SETUP_T;
          d.st = ST_BOOST_OFF;
        end
      end

      ST_BOOST_OFF:
      begin
        if (tmr_zero)
        begin
          d.pd_oe = 1'b0;
          d.mode_dir = 1'b1;
          d.tmr = VERIFY_T;
          d.st = ST_VERIFY;
        end
      end

      ST_VERIFY:
      begin
        if (tmr_zero)
        begin
          d.rb_inv = ~part_data_pins_in;
          if (!q.op_burn_pulse_pin)
          begin
            d.ok = 1'b1;
            d.st = ST_FINISH;
          end
          else if (part_data_pins_in == write_byte)
          begin
            // Zeros left unburned read back as zeros
            d.ok = 1'b1;
            d.st = ST_FINISH;
          end
          else if (!q.retried)
          begin
            d.retried = 1'b1;
            d.mode_dir = 1'b0;
            d.pd_oe = 1'b1;
            d.boost = 1'b1;
            d.tmr = SETUP_T;
            d.st = ST_DATA_SET;
          end
          else
          begin
            d.vfy_err = 1'b1;
            d.st = ST_FINISH;
          end
        end
      end

      ST_FINISH:
      begin
        d.ext_addr = 1'b0;
        d.burn = 1'b0;
        d.boost = 1'b0;
        d.pd_oe = 1'b0;
        d.mode_dir = 1'b1;
        d.route_n = 1'b0;
        d.part_rst_n = 1'b1;
        d.busy = 1'b0;
        d.done = 1'b1;
        d.st = ST_IDLE;
      end

      default:
      begin
        d.st = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.mode_dir <= 1'b1;
      q.part_rst_n <= 1'b1;
      q.range_n <= 1'b1;
      q.rb_inv <= 8'hFF;
    end
    else
    begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !q.ack;
  assign avs_readdata = q.rdata;
  assign returned_byte = q.ret_gate ? q.rb_inv : 8'h00;
  assign returned_byte_oe = q.ret_gate;
  assign range_fault_n = q.range_n;
  assign insertion_fault = q.ins_err;
  assign part_data_pins_out = q.pd_out;
  assign part_data_pins_oe = q.pd_oe;
  assign upper_addr_port = q.upper;
  assign mode_direction_control = q.mode_dir;
  assign part_reset_pulse_n = q.part_rst_n;
  assign ext_address_pin = q.ext_addr;
  assign burn_pulse_pin = q.burn;
  assign supply_boost = q.boost;
endmodule
`default_nettype wire

// >>> inc/eprom_seq_defines.svh
// Purpose: Constants for the target memory program/read sequencer
// Assumes: 200 MHz clk, Avalon-MM register map in byte addresses
`ifndef EPROM_SEQ_DEFINES_SVH
`define EPROM_SEQ_DEFINES_SVH
`define REG_CTRL 2'h0
`define REG_STATUS 2'h1
`define REG_READBACK 2'h2
`define REG_ADDR 2'h3
`define CTRL_GO_READ 0
`define CTRL_GO_BURN_PULSE_PIN 1
`define CTRL_RET_GATE 2
`define CLK_PERIOD_NS 5
`define T_VERIFY_NS 10000
`define T_RESET_NS 1000
`define T_SETUP_NS 500
`define T_BURN_MS 50
`define T_INS_WINDOW_US 1000
`define VERIFY_CYC ((`T_VERIFY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_CYC ((`T_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BURN_CYC (`T_BURN_MS * 1000000 / `CLK_PERIOD_NS)
`define INS_WINDOW_CYC (`T_INS_WINDOW_US * 1000 / `CLK_PERIOD_NS)
`define INS_COUNT_BITS 5
`define MAX_ADDR 1023
`endif

// >>> inc/eprom_seq_pkg.sv
// Purpose: Types for the target memory program/read sequencer
// Assumes: Constants come from eprom_seq_defines.svh
// Notes: States are binary coded
package eprom_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PART_RESET = 4'h1,
    ST_INS_WAIT = 4'h2,
    ST_ADDR_SET = 4'h3,
    ST_ADDR_LATCH = 4'h4,
    ST_ADDR_HOLD = 4'h5,
    ST_DATA_SET = 4'h6,
    ST_BURN = 4'h7,
    ST_BOOST_OFF = 4'h8,
    ST_VERIFY = 4'h9,
    ST_FINISH = 4'hA
  } seq_state_e;
  typedef logic [23:0] timer_t;
endpackage

// >>> dv/eprom_seq_chk.sv
// Purpose: Port checks for the sequencer
// Assumes: Bound to every eprom_seq instance
// Notes: Burn length follows the bound parameter
`timescale 1ns/1ps
`default_nettype none
module eprom_seq_chk
#(
  parameter int unsigned BURN_CYCLES = 50
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [11:0] target_addr,
  input wire logic [7:0] write_byte,
  input wire logic [7:0] returned_byte,
  input wire logic returned_byte_oe,
  input wire logic range_fault_n,
  input wire logic [7:0] part_data_pins_in,
  input wire logic [7:0] part_data_pins_out,
  input wire logic part_data_pins_oe,
  input wire logic [1:0] upper_addr_port,
  input wire logic mode_direction_control,
  input wire logic part_reset_pulse_n,
  input wire logic ext_address_pin,
  input wire logic burn_pulse_pin,
  input wire logic supply_boost
);
  logic [31:0] burn_cnt_q;
  logic [31:0] burn_cnt_d;
  always_comb burn_cnt_d = burn_pulse_pin ? burn_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge clk) burn_cnt_q <= reset_n ? burn_cnt_d : 32'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_req_rise;
    $rose(avs_read) || $rose(avs_write);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_wait_one: assert property (s_req_rise |-> s_one_wait)
    else $error("waitrequest not low after one wait cycle");
  a_range_flag: assert property ($past(reset_n) |->
    range_fault_n == !(|$past(target_addr[11:10])))
    else $error("range fault output wrong");
  a_gate_off: assert property (!returned_byte_oe |->
    returned_byte == 8'h00) else $error("readback driven while gated");
  a_inv_read: assert property (returned_byte_oe &&
    $past(returned_byte_oe) && $past(mode_direction_control) |->
    returned_byte == ~$past(part_data_pins_in))
    else $error("readback not inverted pin byte");
  a_latch_addr: assert property (
    !part_reset_pulse_n && ext_address_pin |->
    part_data_pins_oe && !mode_direction_control &&
    part_data_pins_out == target_addr[7:0] &&
    upper_addr_port == target_addr[9:8]) else $error("latch address wrong");
  a_burn_hv: assert property (burn_pulse_pin |->
    supply_boost && ext_address_pin) else $error("burn without supply");
  a_burn_data: assert property (burn_pulse_pin |->
    part_data_pins_oe && !mode_direction_control &&
    part_data_pins_out == write_byte) else $error("burn data wrong");
  a_burn_len: assert property ($fell(burn_pulse_pin) |->
    burn_cnt_q == BURN_CYCLES + 1) else $error("burn length wrong");
  a_mode_drive: assert property (
    mode_direction_control == !part_data_pins_oe)
    else $error("pin drive and mode line disagree");
endmodule
bind eprom_seq eprom_seq_chk #(.BURN_CYCLES(BURN_CYCLES)) i_eprom_seq_chk (
  .clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .target_addr,
  .write_byte, .returned_byte, .returned_byte_oe, .range_fault_n,
  .part_data_pins_in, .part_data_pins_out, .part_data_pins_oe,
  .upper_addr_port, .mode_direction_control, .part_reset_pulse_n,
  .ext_address_pin, .burn_pulse_pin, .supply_boost);
`default_nettype wire

// >>> dv/eprom_part_model.sv
// Purpose: Behavioural target part in its socket
// Assumes: Pin wire resolved by the bench
// Notes: Absent part gives no fetch strobes and toggling pin data
`timescale 1ns/1ps
`default_nettype none
module eprom_part_model
(
  input wire logic clk,
  input wire logic present,
  input wire logic [7:0] pins,
  input wire logic [1:0] upper,
  input wire logic mode,
  input wire logic rst_n,
  input wire logic ext_addr,
  input wire logic burn,
  input wire logic boost,
  output logic [7:0] drive,
  output logic fetch
);
  logic [7:0] mem [1024];
  logic [9:0] a;
  logic [5:0] n;
  logic rst_q;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    a = 10'h000;
    n = 6'h00;
    rst_q = 1'b1;
    drive = 8'h00;
    fetch = 1'b0;
  end
  always @(posedge clk)
  begin
    rst_q <= rst_n;
    if (rst_n && !rst_q)
    begin
      n <= present ? 6'h28 : 6'h00;
      if (ext_addr)
        a <= {upper, pins};
    end
    else if (n != 6'h00)
      n <= n - 6'h01;
    fetch <= n[0];
    if (burn && boost && ext_addr)
      mem[a] <= mem[a] | pins;
    drive <= (present && mode) ? mem[a] : ~drive;
  end
endmodule
`default_nettype wire

// >>> dv/eprom_seq_bench.sv
// Purpose: Register-level test of the sequencer
// Assumes: Short burn and window counts
// Notes: Status bits 6..0 compared, bit 7 is live
`timescale 1ns/1ps
`default_nettype none
module eprom_seq_bench;
  logic clk, reset_n, avs_read, avs_write, hv_present, present;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, st, q;
  logic avs_waitrequest, returned_byte_oe, range_fault_n, insertion_fault;
  logic [11:0] target_addr;
  logic [7:0] write_byte, returned_byte, pins_out, drive, pins;
  logic pins_oe, mode, rst_n, ext_addr, burn, boost, fetch;
  logic [1:0] upper;
  int tests_run, miscompares;
  assign pins = pins_oe ? pins_out : drive;
  eprom_seq #(.BURN_CYCLES(50), .INS_WINDOW_CYCLES(100)) i_eprom_seq (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .target_addr(target_addr), .write_byte(write_byte),
    .returned_byte(returned_byte), .returned_byte_oe(returned_byte_oe),
    .range_fault_n(range_fault_n), .insertion_fault(insertion_fault),
    .part_data_pins_in(pins), .part_data_pins_out(pins_out),
    .part_data_pins_oe(pins_oe), .upper_addr_port(upper),
    .mode_direction_control(mode), .part_reset_pulse_n(rst_n),
    .ext_address_pin(ext_addr), .burn_pulse_pin(burn),
    .supply_boost(boost), .hv_present(hv_present), .fetch_strobe(fetch));
  eprom_part_model i_eprom_part_model (.clk(clk), .present(present),
    .pins(pins), .upper(upper), .mode(mode), .rst_n(rst_n),
    .ext_addr(ext_addr), .burn(burn), .boost(boost), .drive(drive),
    .fetch(fetch));
  always #2.5 clk = ~clk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic av(input logic wr, input logic [3:0] ad,
    input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (avs_waitrequest !== 1'b0 && i < 50);
    if (i >= 50)
    begin
      chk("waitrequest", 0, 1);
      final_report();
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic op(input logic [11:0] ad, input logic [31:0] go,
    input logic [31:0] e, input string nm);
    int i;
    target_addr <= ad;
    av(1'b1, 4'h0, go, q);
    for (i = 0; i < 4000; i++)
    begin
      av(1'b0, 4'h4, 32'h0, st);
      if (st[1] === 1'b1 && st[0] === 1'b0)
        break;
    end
    if (i == 4000)
    begin
      miscompares++;
      final_report();
    end
    chk(nm, e, st & 32'h7F);
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial
  begin
    clk = 0;
    reset_n = 0;
    avs_address = 0;
    avs_read = 0;
    avs_write = 0;
    avs_writedata = 0;
    avs_byteenable = 4'hF;
    target_addr = 0;
    write_byte = 0;
    hv_present = 1;
    present = 1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    chk("mode_rst", 1, mode);
    op(12'h005, 32'h1, 32'h06, "read_erased");
    av(1'b0, 4'h8, 32'h0, q);
    chk("erased", 32'h00, q);
    av(1'b0, 4'hC, 32'h0, q);
    chk("addr_echo", 32'h005, q);
    write_byte <= 8'hA5;
    op(12'h3FF, 32'h2, 32'h06, "burn_pulse_pin_ok");
    op(12'h3FF, 32'h1, 32'h06, "read_back");
    av(1'b0, 4'h8, 32'h0, q);
    chk("burn_pulse_pin_byte", 32'hA5, q);
    av(1'b1, 4'h0, 32'h4, q);
    av(1'b0, 4'h0, 32'h0, q);
    chk("gate_reg", 32'h4, q);
    repeat (3) @(posedge clk);
    chk("gate_on", 9'h15A, {returned_byte_oe, returned_byte});
    av(1'b1, 4'h0, 32'h0, q);
    repeat (3) @(posedge clk);
    chk("gate_off", 0, {returned_byte_oe, returned_byte});
    write_byte <= 8'h5A;
    op(12'h3FF, 32'h2, 32'h42, "verify_err");
    av(1'b0, 4'h8, 32'h0, q);
    chk("or_byte", 32'hFF, q);
    hv_present <= 1'b0;
    op(12'h010, 32'h2, 32'h22, "hv_abort");
    hv_present <= 1'b1;
    foreach (st[k])
      if (k < 2)
      begin
        target_addr <= k ? 12'h800 : 12'h400;
        repeat (3) @(posedge clk);
        chk("range_pin", 0, range_fault_n);
        op(k ? 12'h800 : 12'h400, 32'h1, 32'h0A, "range");
        av(1'b0, 4'h4, 32'h0, st);
        chk("range_live", 1, st[7]);
      end
    present <= 1'b0;
    op(12'h001, 32'h1, 32'h12, "absent");
    chk("ins_pin", 1, insertion_fault);
    present <= 1'b1;
    op(12'h001, 32'h1, 32'h06, "present");
    chk("ins_clr", 0, insertion_fault);
    final_report();
  end
endmodule
`default_nettype wire
